// >>> spc_regs.sv
// Serial port control and status registers with AXI4-Lite slave
//
// Behaviour
// - Mode bit one selects synchronous operation
// - Sync clock source bit selects master/slave clock
// - Nine-bit transmit bit selects nine data bits
// - Transmit enable; sync receive enables override it
// - Break request cleared when break completes
// - High baud select only in asynchronous mode
// - Shift empty status reads one when empty
// - Transmit ninth bit supplied from register
// - Port enable routes pins; clear resets port
// - Nine-bit receive bit selects nine bits
// - Single receive as master, cleared when done
// - Continuous receive enables, overrides single receive
// - Address detect loads only ninth-bit-set characters
// - Framing flag updates on receive and on port clear
// - Overrun flag cleared by clearing continuous receive
// - Ninth received bit reported, no parity check
// - Auto-baud overflow flag set on timer overflow
// - Receive idle reads zero while receiving
// - Polarity inverts async data, picks sync edge
// - Wide divider bit selects sixteen-bit generator
// - Wake-up waits for falling edge, then self-clears
// - Auto-baud enable clears when detection completes
// - Receive flag set while unread character held and receiver enabled
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module spc_regs
    import spc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Events from the serial datapath (same clock)
    input wire logic tx_shift_loaded,
    input wire logic tx_shift_drained,
    input wire logic tx_break_done,
    input wire logic rx_start_seen,
    input wire logic rx_char_done,
    input wire logic [8:0] rx_char,
    input wire logic rx_char_framing_error_flag,
    input wire logic rx_overrun,
    input wire logic autobaud_done,
    input wire logic autobaud_overflow,
    // Receive line pin (asynchronous)
    input wire logic receive_data_pin,
    // Controls to the serial datapath
    output logic port_active,
    output logic sync_mode,
    output logic sync_master,
    output logic tx_nine_bit_enable,
    output logic tx_active,
    output logic tx_send_break,
    output logic high_baud_active,
    output logic tx_ninth_bit,
    output logic tx_invert_data,
    output logic sync_rising_edge,
    output logic wide_divider_select,
    output logic rx_nine_bit_enable,
    output logic rx_active,
    output logic autobaud_active,
    output logic [7:0] receive_data,
    output logic receive_interrupt_flag
);
    import spc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] txcs;
    logic [7:0] rxcs;
    logic [7:0] bdcs;
    logic [8:0] rx_hold;
    logic rx_hold_framing_error_flag;
    logic rx_full;
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic do_write;
    logic rd_data_take;
    logic [2:0] pin_sync;
    logic pin_level;
    logic wake_fall;

    function automatic logic addr_ok(input logic [3:0] a);
        addr_ok = (a == SPC_ADDR_TXCS) || (a == SPC_ADDR_RXCS)
            || (a == SPC_ADDR_BAUD) || (a == SPC_ADDR_RXDATA);
    endfunction : addr_ok

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nv,
        input logic [7:0] wm);
        merge = (old & ~wm) | (nv & wm);
    endfunction : merge

    wire logic is_sync = txcs[SPC_TX_SYNC];
    wire logic pen = rxcs[SPC_RX_PEN];
    wire logic wr_tx = do_write && w_lane0 && aw_addr == SPC_ADDR_TXCS;
    wire logic wr_rx = do_write && w_lane0 && aw_addr == SPC_ADDR_RXCS;
    wire logic wr_bd = do_write && w_lane0 && aw_addr == SPC_ADDR_BAUD;
    wire logic rd_go = s_axi_arvalid && s_axi_arready;
    // Character accepted unless overrun is set or address detect filters it
    wire logic rx_accept = rx_char_done && !rxcs[SPC_RX_OVERRUN_ERROR_FLAG]
        && !(!is_sync && rxcs[SPC_RX_NINE] && rxcs[SPC_RX_ADDR] && !rx_char[8]);

    // Wake-up: armed, asynchronous and enabled, on a settled falling edge;
    // used both to self-clear the arm bit and to flag the receiver
    wire logic wake_hit = bdcs[SPC_BD_WAKE] && !is_sync && pen && wake_fall;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data taken in either order
    // Ready pulses for one cycle so a valid still high is never taken twice
    // Response is withheld while an earlier one still waits for bready
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= SPC_ADDR_TXCS;
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SPC_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok(aw_addr) ? SPC_RESP_OKAY : SPC_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SPC_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (rd_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= addr_ok(s_axi_araddr) ? SPC_RESP_OKAY : SPC_RESP_SLVERR;
                unique case (s_axi_araddr)
                    SPC_ADDR_TXCS: s_axi_rdata <= {24'h000000, txcs};
                    SPC_ADDR_RXCS: s_axi_rdata <= {24'h000000, rxcs};
                    SPC_ADDR_BAUD: s_axi_rdata <= {24'h000000, bdcs};
                    SPC_ADDR_RXDATA: s_axi_rdata <= {24'h000000, rx_hold[7:0]};
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Reading the data word empties the hold, so status is read before it
    assign rd_data_take = rd_go && s_axi_araddr == SPC_ADDR_RXDATA;

    ////////////////////////////////////////////////////////////////////////
    // Receive pin synchroniser, falling edge for wake-up
    // A level counts only when the last two stages agree, so a single-cycle
    // glitch on the line can never fire a wake-up
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_sync <= 3'h7;
            pin_level <= 1'b1;
        end
        else
        begin
            pin_sync <= {pin_sync[1:0], receive_data_pin};
            if (pin_sync[2] == pin_sync[1])
                pin_level <= pin_sync[1];
        end
    end

    assign wake_fall = pin_level && pin_sync[2] == pin_sync[1] && !pin_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // Transmit control/status; sets by hardware win over software writes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            txcs <= SPC_TX_RESET;
        else
        begin
            if (wr_tx)
                txcs <= merge(txcs, w_data, SPC_TX_WMASK);
            if (!pen)
                txcs[SPC_TX_EMPTY] <= 1'b1;
            else if (tx_shift_loaded)
                txcs[SPC_TX_EMPTY] <= 1'b0;
            else if (tx_shift_drained)
                txcs[SPC_TX_EMPTY] <= 1'b1;
            // A software set in the same cycle wins so a fresh break is not lost
            if (tx_break_done && !is_sync && !(wr_tx && w_data[SPC_TX_BREAK]))
                txcs[SPC_TX_BREAK] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive control/status and receive holding word
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rxcs <= SPC_RX_RESET;
            rx_hold <= 9'h000;
            rx_hold_framing_error_flag <= 1'b0;
            rx_full <= 1'b0;
        end
        else
        begin
            if (wr_rx)
                rxcs <= merge(rxcs, w_data, SPC_RX_WMASK);
            if (rd_data_take)
                rx_full <= 1'b0;
            if (rx_accept && rx_active)
            begin
                rx_hold <= rx_char;
                rx_hold_framing_error_flag <= rx_char_framing_error_flag;
                rx_full <= 1'b1;
            end
            // Flags reflect the held character only
            rxcs[SPC_RX_FRAMING_ERROR_FLAG] <= rx_hold_framing_error_flag;
            rxcs[SPC_RX_D9] <= rx_hold[8];
            // Overrun set beats a same-cycle write clear, not a port disable; it also stops new characters
            if (rx_overrun && rx_active)
                rxcs[SPC_RX_OVERRUN_ERROR_FLAG] <= 1'b1;
            else if (wr_rx && !w_data[SPC_RX_CONT])
                rxcs[SPC_RX_OVERRUN_ERROR_FLAG] <= 1'b0;
            // Single receive ends after one character unless continuous is set
            if (rx_char_done && is_sync && sync_master && !rxcs[SPC_RX_CONT])
                rxcs[SPC_RX_SINGLE] <= 1'b0;
            if (!pen)
            begin
                // Port held in reset: error state and buffer flushed
                rx_full <= 1'b0;
                rx_hold_framing_error_flag <= 1'b0;
                rxcs[SPC_RX_OVERRUN_ERROR_FLAG] <= 1'b0;
                rxcs[SPC_RX_FRAMING_ERROR_FLAG] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Baud control/status
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            bdcs <= SPC_BD_RESET;
        else
        begin
            if (wr_bd)
                bdcs <= merge(bdcs, w_data, SPC_BD_WMASK);
            if (!pen || is_sync || rx_char_done)
                bdcs[SPC_BD_IDLE] <= 1'b1;
            else if (rx_start_seen)
                bdcs[SPC_BD_IDLE] <= 1'b0;
            // Overflow only has meaning while detection runs
            if (autobaud_overflow && !is_sync)
                bdcs[SPC_BD_OVF] <= 1'b1;
            else if (!bdcs[SPC_BD_AUTO] || !pen)
                bdcs[SPC_BD_OVF] <= 1'b0;
            if (autobaud_done && !is_sync)
                bdcs[SPC_BD_AUTO] <= 1'b0;
            if (wake_hit)
                bdcs[SPC_BD_WAKE] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control outputs, all registered
    // Each control trails its register bit by one cycle, receive_interrupt_flag by two through rx_active; the datapath sees
    // only flip-flop outputs, so no decode glitch reaches it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port_active <= 1'b0;
            sync_mode <= 1'b0;
            sync_master <= 1'b0;
            tx_nine_bit_enable <= 1'b0;
            tx_active <= 1'b0;
            tx_send_break <= 1'b0;
            high_baud_active <= 1'b0;
            tx_ninth_bit <= 1'b0;
            tx_invert_data <= 1'b0;
            sync_rising_edge <= 1'b0;
            wide_divider_select <= 1'b0;
            rx_nine_bit_enable <= 1'b0;
            rx_active <= 1'b0;
            autobaud_active <= 1'b0;
            receive_data <= 8'h00;
            receive_interrupt_flag <= 1'b0;
        end
        else
        begin
            port_active <= pen;
            sync_mode <= is_sync;
            sync_master <= is_sync && txcs[SPC_TX_CLOCK_SOURCE_SELECT];
            tx_nine_bit_enable <= txcs[SPC_TX_NINE];
            // Sync receive enables override transmit
            tx_active <= pen && txcs[SPC_TX_EN]
                && !(is_sync && (rxcs[SPC_RX_SINGLE] || rxcs[SPC_RX_CONT]));
            tx_send_break <= pen && !is_sync && txcs[SPC_TX_BREAK];
            high_baud_active <= !is_sync && txcs[SPC_TX_HIGH];
            tx_ninth_bit <= txcs[SPC_TX_D9];
            tx_invert_data <= !is_sync && bdcs[SPC_BD_POL];
            sync_rising_edge <= is_sync && bdcs[SPC_BD_POL];
            wide_divider_select <= bdcs[SPC_BD_WIDE];
            rx_nine_bit_enable <= rxcs[SPC_RX_NINE];
            // Continuous wins; single only as sync master
            rx_active <= pen && !(!is_sync && bdcs[SPC_BD_WAKE]) && (rxcs[SPC_RX_CONT]
                || (is_sync && txcs[SPC_TX_CLOCK_SOURCE_SELECT] && rxcs[SPC_RX_SINGLE]));
            autobaud_active <= pen && !is_sync && bdcs[SPC_BD_AUTO];
            receive_data <= rx_hold[7:0];
            // Wake event flags the receiver once
            receive_interrupt_flag <= pen && ((rx_active && rx_full)
                || wake_hit);
        end
    end
endmodule : spc_regs

// >>> spc_pkg.sv
// Package: register map, field positions and reset values for the serial port control block
package spc_pkg;
    // Register byte addresses
    localparam logic [3:0] SPC_ADDR_TXCS = 4'h0;
    localparam logic [3:0] SPC_ADDR_RXCS = 4'h4;
    localparam logic [3:0] SPC_ADDR_BAUD = 4'h8;
    localparam logic [3:0] SPC_ADDR_RXDATA = 4'hC;
    // transmit_control_status fields
    localparam int SPC_TX_CLOCK_SOURCE_SELECT = 7;
    localparam int SPC_TX_NINE = 6;
    localparam int SPC_TX_EN = 5;
    localparam int SPC_TX_SYNC = 4;
    localparam int SPC_TX_BREAK = 3;
    localparam int SPC_TX_HIGH = 2;
    localparam int SPC_TX_EMPTY = 1;
    localparam int SPC_TX_D9 = 0;
    // receive_control_status fields
    localparam int SPC_RX_PEN = 7;
    localparam int SPC_RX_NINE = 6;
    localparam int SPC_RX_SINGLE = 5;
    localparam int SPC_RX_CONT = 4;
    localparam int SPC_RX_ADDR = 3;
    localparam int SPC_RX_FRAMING_ERROR_FLAG = 2;
    localparam int SPC_RX_OVERRUN_ERROR_FLAG = 1;
    localparam int SPC_RX_D9 = 0;
    // baud_control fields
    localparam int SPC_BD_OVF = 7;
    localparam int SPC_BD_IDLE = 6;
    localparam int SPC_BD_POL = 4;
    localparam int SPC_BD_WIDE = 3;
    localparam int SPC_BD_WAKE = 1;
    localparam int SPC_BD_AUTO = 0;
    // Writable masks and reset values
    localparam logic [7:0] SPC_TX_WMASK = 8'hFD;
    localparam logic [7:0] SPC_RX_WMASK = 8'hF8;
    localparam logic [7:0] SPC_BD_WMASK = 8'h1B;
    localparam logic [7:0] SPC_TX_RESET = 8'h02;
    localparam logic [7:0] SPC_RX_RESET = 8'h00;
    localparam logic [7:0] SPC_BD_RESET = 8'h40;
    localparam logic [1:0] SPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SPC_RESP_SLVERR = 2'h2;
endpackage : spc_pkg

// >>> spc_regs_monitor.sv
// Checker for the serial port control register block
`timescale 1ns/1ps
module spc_regs_monitor
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Controls
    input wire logic port_active,
    input wire logic sync_mode,
    input wire logic sync_master,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic high_baud_active,
    input wire logic tx_send_break,
    input wire logic tx_invert_data
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped early");
    r_latency_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read answer late");
    r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    master_sync_a: assert property (sync_master |-> sync_mode)
        else $error("clock master outside sync mode");
    baud_async_a: assert property (sync_mode |-> !high_baud_active)
        else $error("high baud in sync mode");
    rx_priority_a: assert property (sync_mode && rx_active |-> !tx_active)
        else $error("transmit beat receive in sync mode");
    port_off_a: assert property (!port_active |-> !rx_active && !tx_active)
        else $error("active while port disabled");
    break_async_a: assert property (sync_mode |-> !tx_send_break)
        else $error("break in sync mode");
    pol_mode_a: assert property (sync_mode |-> !tx_invert_data)
        else $error("data inverted in sync mode");
endmodule : spc_regs_monitor

bind spc_regs spc_regs_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .port_active(port_active), .sync_mode(sync_mode), .sync_master(sync_master),
    .tx_active(tx_active), .rx_active(rx_active), .high_baud_active(high_baud_active),
    .tx_send_break(tx_send_break), .tx_invert_data(tx_invert_data));

// >>> spc_peer.sv
// Model of the serial datapath and line facing the register block
`timescale 1ns/1ps
module spc_peer
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bench command: 1..8 pulse one event, 9 pulls the line low
    input wire logic [3:0] cmd,
    // Datapath events and line
    output logic [7:0] ev,
    output logic receive_data_pin
);
    logic [2:0] low_left;
    always_ff @(posedge aclk)
        ev <= (!aresetn || cmd == 4'h0) ? 8'h00 : 8'h01 << (cmd - 4'h1);
    // Line idles high as with a pull-up; a low lasts several cycles because
    // the receiver's filter ignores a single low cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            low_left <= 3'h0;
        else if (cmd == 4'h9)
            low_left <= 3'h4;
        else if (low_left != 3'h0)
            low_left <= low_left - 3'h1;
    end
    assign receive_data_pin = (low_left == 3'h0);
endmodule : spc_peer

// >>> serial_port_control_regs_tb.sv
// Self-checking bench for the serial port control registers
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module serial_port_control_regs_tb;
    import spc_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, rx_char_framing_error_flag, pin, port_active, sync_mode, sync_master;
    logic tx_nine_bit_enable, tx_active, tx_send_break, high_baud_active, tx_ninth_bit;
    logic tx_invert_data, sync_rising_edge, wide_divider_select, rx_nine_bit_enable;
    logic rx_active, autobaud_active, receive_interrupt_flag;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, cmd;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [8:0] rx_char;
    logic [7:0] ev, receive_data;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    // Address, write value, read-back value
    logic [19:0] rows [6] = '{20'h4FFF8, 20'h48080, 20'h0FFFF, 20'h04143, 20'h8FF5B, 20'h81858};
    ////////////////////////////////////////
    spc_regs DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_shift_loaded(ev[0]),
        .tx_shift_drained(ev[1]), .tx_break_done(ev[2]), .rx_start_seen(ev[3]),
        .rx_char_done(ev[4]), .rx_char(rx_char), .rx_char_framing_error_flag(rx_char_framing_error_flag),
        .rx_overrun(ev[5]), .autobaud_done(ev[6]), .autobaud_overflow(ev[7]),
        .receive_data_pin(pin), .port_active(port_active), .sync_mode(sync_mode),
        .sync_master(sync_master), .tx_nine_bit_enable(tx_nine_bit_enable),
        .tx_active(tx_active), .tx_send_break(tx_send_break),
        .high_baud_active(high_baud_active), .tx_ninth_bit(tx_ninth_bit),
        .tx_invert_data(tx_invert_data), .sync_rising_edge(sync_rising_edge),
        .wide_divider_select(wide_divider_select), .rx_nine_bit_enable(rx_nine_bit_enable),
        .rx_active(rx_active), .autobaud_active(autobaud_active),
        .receive_data(receive_data), .receive_interrupt_flag(receive_interrupt_flag));
    spc_peer u_peer (.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .ev(ev),
        .receive_data_pin(pin));
    ////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h000000, v};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
    endtask : rd
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        rd(a);
        `CHK("register", {24'h000000, e}, d)
    endtask : rchk
    task automatic pulse(input logic [3:0] c);
        @(posedge aclk);
        cmd <= c;
        @(posedge aclk);
        cmd <= 4'h0;
        repeat (3) @(posedge aclk);
    endtask : pulse
    // Outputs follow the register one cycle late
    task automatic settle;
        repeat (2) @(posedge aclk);
        #1;
    endtask : settle
    ////////////////////////////////////////
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            summarize();
        end
    end
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, rx_char_framing_error_flag, s_axi_awaddr, s_axi_araddr, cmd, rx_char} = '0;
        s_axi_wstrb = 4'hF;
        s_axi_wdata = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        `CHK("port_active", 1'b0, port_active)
        rchk(SPC_ADDR_TXCS, 8'h02);
        rchk(SPC_ADDR_RXCS, 8'h00);
        rchk(SPC_ADDR_BAUD, 8'h40);
        $display("reset test done");
        for (int i = 0; i < 6; i++)
        begin
            wr(rows[i][19:16], rows[i][15:8]);
            rchk(rows[i][19:16], rows[i][7:0]);
        end
        settle();
        `CHK("tx_nine_bit_enable", 1'b1, tx_nine_bit_enable)
        `CHK("tx_ninth_bit", 1'b1, tx_ninth_bit)
        `CHK("tx_invert_data", 1'b1, tx_invert_data)
        `CHK("wide_divider_select", 1'b1, wide_divider_select)
        rd(4'h2);
        `CHK("rresp", SPC_RESP_SLVERR, s_axi_rresp)
        `CHK("rdata", 32'h0000_0000, d)
        wr(4'h2, 8'hFF);
        `CHK("bresp", SPC_RESP_SLVERR, s_axi_bresp)
        $display("table test done");
        wr(SPC_ADDR_TXCS, 8'hB4);
        settle();
        `CHK("sync_mode", 1'b1, sync_mode)
        `CHK("sync_master", 1'b1, sync_master)
        `CHK("high_baud_active", 1'b0, high_baud_active)
        `CHK("tx_active", 1'b1, tx_active)
        `CHK("sync_rising_edge", 1'b1, sync_rising_edge)
        `CHK("tx_invert_data", 1'b0, tx_invert_data)
        wr(SPC_ADDR_RXCS, 8'hA0);
        settle();
        `CHK("tx_active", 1'b0, tx_active)
        pulse(4'h5);
        rchk(SPC_ADDR_RXCS, 8'h80);
        rchk(SPC_ADDR_RXDATA, 8'h00);
        wr(SPC_ADDR_TXCS, 8'h8C);
        settle();
        `CHK("sync_master", 1'b0, sync_master)
        `CHK("high_baud_active", 1'b1, high_baud_active)
        `CHK("tx_send_break", 1'b1, tx_send_break)
        pulse(4'h3);
        rchk(SPC_ADDR_TXCS, 8'h86);
        pulse(4'h1);
        rchk(SPC_ADDR_TXCS, 8'h84);
        pulse(4'h2);
        rchk(SPC_ADDR_TXCS, 8'h86);
        $display("transmit test done");
        wr(SPC_ADDR_RXCS, 8'hD0);
        rx_char <= 9'h1A5;
        rx_char_framing_error_flag <= 1'b1;
        pulse(4'h4);
        rchk(SPC_ADDR_BAUD, 8'h18);
        pulse(4'h5);
        rchk(SPC_ADDR_RXCS, 8'hD5);
        `CHK("receive_interrupt_flag", 1'b1, receive_interrupt_flag)
        `CHK("receive_data", 8'hA5, receive_data)
        `CHK("rx_nine_bit_enable", 1'b1, rx_nine_bit_enable)
        `CHK("rx_active", 1'b1, rx_active)
        rchk(SPC_ADDR_RXDATA, 8'hA5);
        settle();
        `CHK("receive_interrupt_flag", 1'b0, receive_interrupt_flag)
        rchk(SPC_ADDR_BAUD, 8'h58);
        wr(SPC_ADDR_RXCS, 8'hD8);
        rx_char <= 9'h033;
        rx_char_framing_error_flag <= 1'b0;
        pulse(4'h5);
        settle();
        `CHK("receive_interrupt_flag", 1'b0, receive_interrupt_flag)
        rx_char <= 9'h155;
        pulse(4'h5);
        rchk(SPC_ADDR_RXDATA, 8'h55);
        pulse(4'h6);
        rd(SPC_ADDR_RXCS);
        `CHK("overrun", 1'b1, d[1])
        wr(SPC_ADDR_RXCS, 8'hC8);
        rd(SPC_ADDR_RXCS);
        `CHK("overrun", 1'b0, d[1])
        $display("receive test done");
        wr(SPC_ADDR_BAUD, 8'h01);
        settle();
        `CHK("autobaud_active", 1'b1, autobaud_active)
        pulse(4'h8);
        rchk(SPC_ADDR_BAUD, 8'hC1);
        pulse(4'h7);
        rchk(SPC_ADDR_BAUD, 8'h40);
        wr(SPC_ADDR_BAUD, 8'h02);
        pulse(4'h9);
        rchk(SPC_ADDR_BAUD, 8'h40);
        wr(SPC_ADDR_RXCS, 8'h00);
        settle();
        `CHK("port_active", 1'b0, port_active)
        `CHK("rx_active", 1'b0, rx_active)
        $display("baud and disable test done");
        summarize();
    end
endmodule : serial_port_control_regs_tb
